// ==== hw/swcp_chan.sv ====
`timescale 1ns/1ns
`default_nettype none
module swcp_chan
    import swcp_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       combine_and_i,
    input  wire logic [5:0] chan_on_i,
    input  wire logic [5:0] pin_i,
    input  wire logic [5:0] over_temp_i,
    input  wire logic [4:0] dyn_temp_i,
    input  wire logic       clr_latch_i,
    output logic [5:0]      drive_o,
    output logic [5:0]      ot_latch_o
);

    swcp_chan_s q;
    swcp_chan_s d;
    logic [5:0] request;
    logic [5:0] dyn_off;

    // ======================================================================
    // Request combining and protection gating
    // ======================================================================
    always_comb
    begin
        d = q;
        request = combine_and_i ? (pin_i & chan_on_i) : (pin_i | chan_on_i);
        dyn_off = {1'b0, dyn_temp_i};
        // A hot channel keeps its latch through a clear, so cooling is needed too.
        d.ot_latch = (q.ot_latch & ~{6{clr_latch_i}}) | over_temp_i;
        d.drive = request & ~q.ot_latch & ~over_temp_i & ~dyn_off;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign drive_o = q.drive;
    assign ot_latch_o = q.ot_latch;

endmodule
`default_nettype wire

// ==== hw/swcp_defs.svh ====
`ifndef SWCP_DEFS_SVH
`define SWCP_DEFS_SVH

// ==========================================================================
// Frame layout, eight bits, most significant bit first
// ==========================================================================
`define SWCP_FRAME_BITS     4'h8
`define SWCP_BIT_WRITE      7
`define SWCP_BIT_RB         6
`define SWCP_ADDR_HI        5
`define SWCP_ADDR_LO        4

// ==========================================================================
// Register select codes with the RB bit set
// ==========================================================================
`define SWCP_ADDR_CFG       2'h1
`define SWCP_ADDR_CMD       2'h2

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define SWCP_BIT_COMBINE    3
`define SWCP_BIT_CLR_LATCH  0
`define SWCP_RST_CHAN_ON    6'h00
`define SWCP_RST_COMBINE    1'h0
`define SWCP_RST_LAMP       3'h0

`endif

// ==== hw/swcp_pkg.sv ====
package swcp_pkg;

    typedef enum logic [1:0] {SWCP_SEL_DIAG, SWCP_SEL_OUT, SWCP_SEL_CFG} swcp_sel_e;

    typedef struct packed {
        logic [4:0] dyn_temp;
        logic [5:0] over_temp;
        logic [5:0] pin;
        logic       mosi;
        logic       sclk;
        logic       cs_n;
    } swcp_pins_s;

    typedef struct packed {
        logic       cs_prev;
        logic       sclk_prev;
        logic [3:0] cnt;
        logic [7:0] shift_in;
        logic [7:0] shift_out;
        logic       miso;
        logic       miso_oe;
        logic       start;
        logic       done;
        logic [7:0] rx;
    } swcp_spi_s;

    typedef struct packed {
        logic [5:0] ot_latch;
        logic [5:0] drive;
    } swcp_chan_s;

    typedef struct packed {
        swcp_pins_s meta;
        swcp_pins_s sync;
        logic [5:0] chan_on;
        logic       combine_and;
        logic [2:0] lamp;
        logic [5:0] err;
        logic [5:0] err_sent;
        logic       sent_diag;
        swcp_sel_e  sel;
        logic       clr_latch;
    } swcp_top_s;

    // Register select field of a frame compared with a code.
    function automatic logic swcp_addr_is(input logic [7:0] frame, input logic [1:0] code);
        return frame[6] && (frame[5:4] == code);
    endfunction

endpackage

// ==== hw/swcp_spi.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "swcp_defs.svh"
module swcp_spi
    import swcp_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic [7:0] tx_word_i,
    output logic            miso_o,
    output logic            miso_oe_o,
    output logic            frame_start_o,
    output logic            frame_done_o,
    output logic [7:0]      rx_word_o
);

    swcp_spi_s q;
    swcp_spi_s d;

    // ======================================================================
    // Shifter: sample on rising SCLK, shift out on falling SCLK
    // ======================================================================
    always_comb
    begin
        d = q;
        d.start = 1'b0;
        d.done = 1'b0;
        d.cs_prev = cs_n_i;
        d.sclk_prev = sclk_i;
        if (q.cs_prev && !cs_n_i)
        begin
            d.shift_out = tx_word_i;
            d.miso = tx_word_i[7];
            d.miso_oe = 1'b1;
            d.cnt = 4'h0;
            d.start = 1'b1;
        end
        else if (!q.cs_prev && cs_n_i)
        begin
            d.miso_oe = 1'b0;
            d.miso = 1'b0;
            // A frame of any other length is thrown away whole.
            if (q.cnt == `SWCP_FRAME_BITS)
            begin
                d.done = 1'b1;
                d.rx = q.shift_in;
            end
        end
        else if (!cs_n_i)
        begin
            if (sclk_i && !q.sclk_prev)
            begin
                d.shift_in = {q.shift_in[6:0], mosi_i};
                // Saturating keeps a long frame from wrapping back to eight.
                if (q.cnt != 4'hf)
                begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            else if (!sclk_i && q.sclk_prev)
            begin
                d.shift_out = {q.shift_out[6:0], 1'b0};
                d.miso = q.shift_out[6];
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            q <= '0;
            q.cs_prev <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign miso_o = q.miso;
    assign miso_oe_o = q.miso_oe;
    assign frame_start_o = q.start;
    assign frame_done_o = q.done;
    assign rx_word_o = q.rx;

endmodule
`default_nettype wire

// ==== hw/swcp_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "swcp_defs.svh"
module swcp_top
    import swcp_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic       spi_cs_n_i,
    input  wire logic       spi_sclk_i,
    input  wire logic       spi_mosi_i,
    output logic            spi_miso_o,
    output logic            spi_miso_oe_o,
    input  wire logic [5:0] channel_input_pin_i,
    input  wire logic [5:0] over_temp_i,
    input  wire logic [4:0] dyn_temp_i,
    output logic [5:0]      chan_drive_o,
    output logic [5:0]      thermal_latch_o,
    output logic [5:0]      err_flag_o,
    output logic [2:0]      lamp_type_select_o
);

    swcp_top_s  q;
    swcp_top_s  d;
    swcp_pins_s pins;
    logic [7:0] tx_word;
    logic       frame_start;
    logic       frame_done;
    logic [7:0] rx_word;
    logic [5:0] ot_latch;
    logic [5:0] err_set;
    logic [5:0] err_clr;

    // ======================================================================
    // Pin bundle
    // ======================================================================
    // Every pin is asynchronous to sys_clk_i, SCLK included, so all of them
    // pass the same two flops before any logic looks at them.
    always_comb
    begin
        pins.cs_n = spi_cs_n_i;
        pins.sclk = spi_sclk_i;
        pins.mosi = spi_mosi_i;
        pins.pin = channel_input_pin_i;
        pins.over_temp = over_temp_i;
        pins.dyn_temp = dyn_temp_i;
    end

    // ======================================================================
    // Answer word for the frame now starting
    // ======================================================================
    always_comb
    begin
        tx_word = 8'h00;
        unique case (q.sel)
            SWCP_SEL_DIAG:
            begin
                tx_word = {2'h0, q.err};
            end
            SWCP_SEL_OUT:
            begin
                tx_word = {2'h0, q.chan_on};
            end
            SWCP_SEL_CFG:
            begin
                tx_word = {4'h0, q.combine_and, q.lamp};
            end
        endcase
    end

    // ======================================================================
    // Serial link
    // ======================================================================
    swcp_spi u_spi (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .cs_n_i        (q.sync.cs_n),
        .sclk_i        (q.sync.sclk),
        .mosi_i        (q.sync.mosi),
        .tx_word_i     (tx_word),
        .miso_o        (spi_miso_o),
        .miso_oe_o     (spi_miso_oe_o),
        .frame_start_o (frame_start),
        .frame_done_o  (frame_done),
        .rx_word_o     (rx_word)
    );

    // ======================================================================
    // Channel drive and thermal latches
    // ======================================================================
    swcp_chan u_chan (
        .sys_clk_i     (sys_clk_i),
        .reset_i       (reset_i),
        .combine_and_i (q.combine_and),
        .chan_on_i     (q.chan_on),
        .pin_i         (q.sync.pin),
        .over_temp_i   (q.sync.over_temp),
        .dyn_temp_i    (q.sync.dyn_temp),
        .clr_latch_i   (q.clr_latch),
        .drive_o       (chan_drive_o),
        .ot_latch_o    (ot_latch)
    );

    // ======================================================================
    // Register file, command decode and error flags
    // ======================================================================
    always_comb
    begin
        d = q;
        d.meta = pins;
        d.sync = q.meta;
        d.clr_latch = 1'b0;

        // Flags are snapshotted a cycle after the answer word is loaded, and only snapshotted flags clear.
        if (frame_start)
        begin
            d.sent_diag = (q.sel == SWCP_SEL_DIAG);
            d.err_sent = q.err;
        end

        err_clr = 6'h00;
        if (frame_done && q.sent_diag)
        begin
            err_clr = q.err_sent;
        end
        // Set wins over clear, so a channel still shut down flags again.
        err_set = {1'b0, q.sync.dyn_temp} | ot_latch;
        d.err = (q.err & ~err_clr) | err_set;

        if (frame_done)
        begin
            d.sel = SWCP_SEL_DIAG;
            if (rx_word[`SWCP_BIT_WRITE])
            begin
                if (!rx_word[`SWCP_BIT_RB])
                begin
                    d.chan_on = rx_word[5:0];
                end
                else if (swcp_addr_is(rx_word, `SWCP_ADDR_CFG))
                begin
                    d.combine_and = rx_word[`SWCP_BIT_COMBINE];
                    d.lamp = rx_word[2:0];
                end
                else if (swcp_addr_is(rx_word, `SWCP_ADDR_CMD))
                begin
                    d.clr_latch = rx_word[`SWCP_BIT_CLR_LATCH];
                end
            end
            else
            begin
                // A read frame picks the word returned in the next frame.
                if (!rx_word[`SWCP_BIT_RB])
                begin
                    d.sel = SWCP_SEL_OUT;
                end
                else if (swcp_addr_is(rx_word, `SWCP_ADDR_CFG))
                begin
                    d.sel = SWCP_SEL_CFG;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            q <= '0;
            q.meta.cs_n <= 1'b1;
            q.sync.cs_n <= 1'b1;
            q.chan_on <= `SWCP_RST_CHAN_ON;
            q.combine_and <= `SWCP_RST_COMBINE;
            q.lamp <= `SWCP_RST_LAMP;
            q.sel <= SWCP_SEL_DIAG;
        end
        else
        begin
            q <= d;
        end
    end

    assign thermal_latch_o = ot_latch;
    assign err_flag_o = q.err;
    assign lamp_type_select_o = q.lamp;

endmodule
`default_nettype wire

// ==== tb/swcp_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module swcp_host
    import swcp_pkg::*;
(
    output var logic cs_n_o,
    output var logic sclk_o,
    output var logic mosi_o,
    input  wire logic miso_i
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    // ==========================================================
    // Mode 0 frame, most significant first
    // ==========================================================
    // A count below eight sends a cut frame that the block must throw away.
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx, input int bits);
        cs_n_o = 1'b0;
        for (int i = 7; i > 7 - bits; i--)
        begin
            mosi_o = tx[i];
            #80 sclk_o = 1'b1;
            rx[i] = miso_i;
            #80 sclk_o = 1'b0;
        end
        #80 cs_n_o = 1'b1;
        // Data is not held once deselected, so stale bits cannot look valid.
        mosi_o = ~mosi_o;
        #80;
    endtask
endmodule
`default_nettype wire

// ==== tb/swcp_top_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module swcp_top_monitor
    import swcp_pkg::*;
(
    input wire logic       sys_clk_i,
    input wire logic       reset_i,
    input wire logic       spi_cs_n_i,
    input wire logic       spi_sclk_i,
    input wire logic       spi_mosi_i,
    input wire logic       spi_miso_o,
    input wire logic       spi_miso_oe_o,
    input wire logic [5:0] channel_input_pin_i,
    input wire logic [5:0] over_temp_i,
    input wire logic [4:0] dyn_temp_i,
    input wire logic [5:0] chan_drive_o,
    input wire logic [5:0] thermal_latch_o,
    input wire logic [5:0] err_flag_o,
    input wire logic [2:0] lamp_type_select_o
);
    // ==========================================================
    // Fault history
    // ==========================================================
    // A fault counts only after five samples, so the synchroniser delay never trips a check.
    logic [3:0][5:0] ot_h_q;
    logic [3:0][4:0] dy_h_q;
    logic [5:0]      ot_all;
    logic [4:0]      dy_all;
    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ot_h_q <= '0;
            dy_h_q <= '0;
        end
        else
        begin
            ot_h_q <= {ot_h_q[2:0], over_temp_i};
            dy_h_q <= {dy_h_q[2:0], dyn_temp_i};
        end
    end
    assign ot_all = over_temp_i & ot_h_q[0] & ot_h_q[1] & ot_h_q[2] & ot_h_q[3];
    assign dy_all = dyn_temp_i & dy_h_q[0] & dy_h_q[1] & dy_h_q[2] & dy_h_q[3];

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    oe_on_frame_a:
        assert property ($fell(spi_cs_n_i) |-> ##[1:6] spi_miso_oe_o)
            else $error("miso enable missing after select");
    oe_off_idle_a:
        assert property ($rose(spi_cs_n_i) |-> ##[1:6] !spi_miso_oe_o)
            else $error("miso enable stuck after deselect");
    ot_drive_off_a:
        assert property ((chan_drive_o & ot_all) == 6'h00)
            else $error("hot channel still driven");
    ot_latch_set_a:
        assert property ((ot_all & ~thermal_latch_o) == 6'h00)
            else $error("hot channel not latched");
    latch_blocks_a:
        assert property ((thermal_latch_o & chan_drive_o) == 6'h00)
            else $error("latched channel driven");
    latch_hold_a:
        assert property (!spi_cs_n_i [*8] |-> (~thermal_latch_o & $past(thermal_latch_o)) == 6'h00)
            else $error("thermal latch dropped without command");
    dyn_drive_off_a:
        assert property ((chan_drive_o[4:0] & dy_all) == 5'h00)
            else $error("channel driven in dynamic shutdown");
    dyn_err_set_a:
        assert property ((dy_all & ~err_flag_o[4:0]) == 5'h00)
            else $error("error flag low in dynamic shutdown");
    err_hold_a:
        assert property (!spi_cs_n_i [*8] |-> (~err_flag_o & $past(err_flag_o)) == 6'h00)
            else $error("error flag cleared inside a frame");
    lamp_hold_a:
        assert property (!spi_cs_n_i [*8] |-> $stable(lamp_type_select_o))
            else $error("lamp type changed inside a frame");
endmodule
bind swcp_top swcp_top_monitor swcp_top_monitor_inst (
    .sys_clk_i, .reset_i, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i, .spi_miso_o,
    .spi_miso_oe_o, .channel_input_pin_i, .over_temp_i, .dyn_temp_i, .chan_drive_o,
    .thermal_latch_o, .err_flag_o, .lamp_type_select_o);
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        sys_clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [5:0]  channel_input_pin_i = 6'h00;
    logic [5:0]  over_temp_i = 6'h00;
    logic [4:0]  dyn_temp_i = 5'h00;
    wire         spi_cs_n_i, spi_sclk_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o;
    wire  [5:0]  chan_drive_o, thermal_latch_o, err_flag_o;
    wire  [2:0]  lamp_type_select_o;
    int          n_fail = 0;
    int          n_tests = 0;
    logic [20:0] oq[$];
    logic [7:0]  rq[$];
    logic [7:0]  rx_seen;
    event        out_ev, rx_ev;

    always #5 sys_clk_i = ~sys_clk_i;

    swcp_top swcp_top_inst (.sys_clk_i, .reset_i, .spi_cs_n_i, .spi_sclk_i, .spi_mosi_i,
        .spi_miso_o, .spi_miso_oe_o, .channel_input_pin_i, .over_temp_i, .dyn_temp_i,
        .chan_drive_o, .thermal_latch_o, .err_flag_o, .lamp_type_select_o);
    swcp_host swcp_host_inst (.cs_n_o(spi_cs_n_i), .sclk_o(spi_sclk_i),
        .mosi_o(spi_mosi_i), .miso_i(spi_miso_o));

    // ==========================================================
    // Checking
    // ==========================================================
    task automatic check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(out_ev)
        check("outputs", {chan_drive_o, thermal_latch_o, err_flag_o, lamp_type_select_o},
            oq.pop_front());
    always @(rx_ev)
        check("answer", {13'h0000, rx_seen}, {13'h0000, rq.pop_front()});

    // ==========================================================
    // Stimulus
    // ==========================================================
    task automatic settle(input logic [20:0] e);
        repeat (12) @(posedge sys_clk_i);
        #1;
        oq.push_back(e);
        ->out_ev;
    endtask

    task automatic xfer(input logic [7:0] tx, input logic [7:0] exp);
        rq.push_back(exp);
        swcp_host_inst.frame(tx, rx_seen, 8);
        ->rx_ev;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk_i);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        logic [5:0] b, p;
        logic [7:0] nx;
        logic [2:0] l;
        logic       c;
        void'($urandom(53));
        repeat (16) @(posedge sys_clk_i);
        #1 reset_i = 1'b0;
        settle(21'h000000);
        xfer(8'h50, 8'h00);
        xfer(8'h00, 8'h00);
        nx = 8'h00;
        for (int i = 0; i < 6; i++)
        begin
            b = 6'($urandom);
            p = 6'($urandom);
            l = 3'($urandom);
            c = i[0];
            channel_input_pin_i = p;
            xfer({2'b10, b}, nx);
            xfer({4'hd, c, l}, 8'h00);
            settle({c ? (b & p) : (b | p), 12'h000, l});
            xfer(8'h50, 8'h00);
            xfer(8'h00, {4'h0, c, l});
            nx = {2'b00, b};
        end
        channel_input_pin_i = 6'h00;
        xfer(8'hd0, nx);
        xfer(8'hbf, 8'h00);
        over_temp_i = 6'h21;
        settle({6'h1e, 6'h21, 6'h21, 3'h0});
        over_temp_i = 6'h20;
        settle({6'h1e, 6'h21, 6'h21, 3'h0});
        xfer(8'he0, 8'h21);
        settle({6'h1e, 6'h21, 6'h21, 3'h0});
        xfer(8'he1, 8'h21);
        settle({6'h1f, 6'h20, 6'h21, 3'h0});
        over_temp_i = 6'h00;
        xfer(8'he1, 8'h21);
        settle({6'h3f, 6'h00, 6'h20, 3'h0});
        dyn_temp_i = 5'h1f;
        settle({6'h20, 6'h00, 6'h3f, 3'h0});
        dyn_temp_i = 5'h00;
        settle({6'h3f, 6'h00, 6'h3f, 3'h0});
        xfer(8'h00, 8'h3f);
        settle({6'h3f, 6'h00, 6'h00, 3'h0});
        dyn_temp_i = 5'h04;
        xfer(8'hbf, 8'h3f);
        xfer(8'hbf, 8'h04);
        settle({6'h3b, 6'h00, 6'h04, 3'h0});
        dyn_temp_i = 5'h00;
        xfer(8'hbf, 8'h04);
        settle({6'h3f, 12'h000, 3'h0});
        // Seven bits of zero would clear every channel bit if the cut frame were taken.
        swcp_host_inst.frame(8'h00, rx_seen, 7);
        settle({6'h3f, 12'h000, 3'h0});
        xfer(8'h00, 8'h00);
        xfer(8'h60, 8'h3f);
        xfer(8'h00, 8'h00);
        #1;
        wrap_up();
    end
endmodule
`default_nettype wire
